// File: hw/sub_datapath.sv
`timescale 1ns/1ps
`default_nettype none
// executes the two subtract operations over four phases
module sub_datapath
(
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     nrst_i,
  // instruction and register read data
  input  wire logic [13:0]              insn_i,
  input  wire logic [7:0]               file_rdata_i,
  // phase and decode
  output logic      [1:0]               phase_o,
  output logic                          busy_o,
  // register file access
  output logic      [6:0]               file_raddr_o,
  output sub_dp_pkg::file_wr_t          file_wr_o,
  // architectural state
  output logic      [7:0]               acc_o,
  output sub_dp_pkg::flags_t            flags_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    sub_dp_pkg::phase_t   phase;    // quarter cycle
    sub_dp_pkg::op_t      op;       // latched decode
    logic                 dest;     // destination select
    logic [6:0]           idx;      // register index
    logic [7:0]           operand;  // fetched minuend
    logic [7:0]           diff;     // computed result
    sub_dp_pkg::flags_t   nflags;   // computed flags
    logic [7:0]           acc;      // accumulator
    sub_dp_pkg::flags_t   flags;    // status flags
    sub_dp_pkg::file_wr_t wr;       // register write pulse
  } state_t;

  state_t st;
  state_t next_st;

  logic [7:0]         alu_diff;
  sub_dp_pkg::flags_t alu_flags;

  sub_alu #(.DATA_W(8)) u_alu
  (
    .minuend_i (st.operand),
    .acc_i     (st.acc),
    .diff_o    (alu_diff),
    .flags_o   (alu_flags)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    next_st.wr.we = 1'b0;  // write is a one-phase pulse
    next_st.phase = sub_dp_pkg::phase_t'(st.phase + 2'h1);
    unique case (st.phase)
      sub_dp_pkg::PH_DECODE:
      begin
        // decode; any other word still latches idx, dest and operand but sets no op
        next_st.idx  = insn_i[6:0];
        next_st.dest = insn_i[sub_dp_pkg::DEST_BIT];
        if (insn_i[13:8] == sub_dp_pkg::FILE_OPC)        // see RQ5
          next_st.op = sub_dp_pkg::OP_FILE;
        else if (insn_i[13:9] == sub_dp_pkg::LIT_OPC)    // see RQ8
          next_st.op = sub_dp_pkg::OP_LIT;
        else
          next_st.op = sub_dp_pkg::OP_NONE;
        next_st.operand = insn_i[7:0];                   // see RQ1
      end
      sub_dp_pkg::PH_READ:
      begin
        // literal already captured; register op reads now
        if (st.op == sub_dp_pkg::OP_FILE)
          next_st.operand = file_rdata_i;                // see RQ7
      end
      sub_dp_pkg::PH_PROCESS:
      begin
        next_st.diff   = alu_diff;                       // see RQ6
        next_st.nflags = alu_flags;
      end
      sub_dp_pkg::PH_WRITE:
      begin
        if (st.op != sub_dp_pkg::OP_NONE)
        begin
          next_st.flags = st.nflags;                     // see RQ6
          // literal op always writes the accumulator
          if (st.op == sub_dp_pkg::OP_LIT || !st.dest)   // see RQ9
            next_st.acc = st.diff;                       // see RQ1
          else
          begin
            // accumulator untouched when file is target
            next_st.wr.we   = 1'b1;                      // see RQ7
            next_st.wr.idx  = st.idx;
            next_st.wr.data = st.diff;
          end
        end
        next_st.op = sub_dp_pkg::OP_NONE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st       <= '0;
      st.acc   <= sub_dp_pkg::ACC_RST;
      st.phase <= sub_dp_pkg::PH_DECODE;
    end
    else
      st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the read address is the latched index, valid through the read phase
  assign phase_o      = st.phase;
  assign busy_o       = (st.op != sub_dp_pkg::OP_NONE);
  assign file_raddr_o = st.idx;
  assign file_wr_o    = st.wr;
  assign acc_o        = st.acc;
  assign flags_o      = st.flags;

endmodule // sub_datapath
`default_nettype wire

// File: hw/sub_dp_pkg.sv
// Function
// RQ1: literal op: decode, fetch, compute, write phases
// RQ2: minuend above accumulator sets carry
// RQ3: equal operands give zero, carry, zero flag
// RQ4: accumulator larger clears flags, result modulo 256; code clears carry and zero, nibble follows low borrow
// RQ5: register op opcode 00 0010, d, index
// RQ6: register op updates carry, nibble, zero only
// RQ7: register op phases; file destination keeps accumulator
// RQ8: literal op encoding 11 110x plus immediate
// RQ9: destination bit 0 accumulator, 1 register
// RQ10: nibble flag set when no low borrow
package sub_dp_pkg;

  // ****************************************************************
  // encoding
  // ****************************************************************
  localparam int          INSN_W      = 14;
  localparam int          DATA_W      = 8;
  localparam int          IDX_W       = 7;
  localparam logic [5:0]  FILE_OPC    = 6'h02;  // 00 0010
  localparam logic [4:0]  LIT_OPC     = 5'h1E;  // 11 110x
  localparam int          DEST_BIT    = 7;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [1:0]  PHASE_LAST  = 2'h3;

  // quarter-cycle phases of one instruction cycle
  typedef enum logic [1:0]
  {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  // decoded operation
  typedef enum logic [1:0]
  {
    OP_NONE    = 2'b00,
    OP_LIT     = 2'b01,
    OP_FILE    = 2'b10
  } op_t;

  // status flags carried as one group
  typedef struct packed
  {
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
  } flags_t;

  // register-file write request
  typedef struct packed
  {
    logic             we;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } file_wr_t;

endpackage : sub_dp_pkg

// File: hw/sub_alu.sv
`timescale 1ns/1ps
`default_nettype none
// minuend minus accumulator with inverted-borrow flags
module sub_alu
#(
  parameter int DATA_W = 8
)
(
  // operands
  input  wire logic [DATA_W-1:0] minuend_i,
  input  wire logic [DATA_W-1:0] acc_i,
  // results
  output logic      [DATA_W-1:0] diff_o,
  output sub_dp_pkg::flags_t     flags_o
);

  logic [DATA_W:0] full;  // one extra bit holds the borrow
  logic [4:0]      low;   // low nibble with its borrow

  // ****************************************************************
  // subtraction
  // ****************************************************************
  always_comb
  begin
    full = {1'b0, minuend_i} - {1'b0, acc_i};
    low  = {1'b0, minuend_i[3:0]} - {1'b0, acc_i[3:0]};
    diff_o = full[DATA_W-1:0];                          // see RQ4
    flags_o.carry = ~full[DATA_W];                      // see RQ2
    flags_o.nibble_borrow_flag = ~low[4];               // see RQ10
    flags_o.zero = (full[DATA_W-1:0] == '0);            // see RQ3
  end

endmodule // sub_alu
`default_nettype wire

// File: testbench/sub_datapath_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module sub_datapath_checker
(
  // clock, reset, inputs
  input wire logic                 sys_clk_i,
  input wire logic                 nrst_i,
  input wire logic [13:0]          insn_i,
  // design outputs
  input wire logic [1:0]           phase_o,
  input wire logic                 busy_o,
  input wire logic [6:0]           file_raddr_o,
  input wire sub_dp_pkg::file_wr_t file_wr_o,
  input wire logic [7:0]           acc_o,
  input wire sub_dp_pkg::flags_t   flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // a subtract word taken at decode
  logic take_sub;
  assign take_sub = phase_o == 2'h0 &&
    (insn_i[13:8] == sub_dp_pkg::FILE_OPC ||
     insn_i[13:9] == sub_dp_pkg::LIT_OPC);
  phase_step_a: assert property ($past(nrst_i) |->
    phase_o == $past(phase_o) + 2'h1) else $error("phase skipped");
  busy_run_a: assert property (take_sub |=> busy_o [*3] ##1 !busy_o)
    else $error("busy span wrong");
  raddr_hold_a: assert property (take_sub && !insn_i[13] |=>
    file_raddr_o == $past(insn_i[6:0])) else $error("index lost");
  acc_when_a: assert property ($changed(acc_o) |->
    phase_o == 2'h0 && $past(busy_o)) else $error("acc write early");
  flag_when_a: assert property ($changed(flags_o) |->
    phase_o == 2'h0 && $past(busy_o)) else $error("flag write early");
  we_pulse_a: assert property (file_wr_o.we |=> !file_wr_o.we)
    else $error("write too long");
  file_keep_a: assert property (file_wr_o.we |->
    $stable(acc_o) && phase_o == 2'h0) else $error("acc hit");
  zero_file_a: assert property (file_wr_o.we |->
    flags_o.zero == (file_wr_o.data == 8'h00)) else $error("zero bad");
  zero_acc_a: assert property ($changed(acc_o) |->
    flags_o.zero == (acc_o == 8'h00)) else $error("zero acc bad");
  cover property (file_wr_o.we);
  cover property ($changed(acc_o) && flags_o.zero);
  cover property (busy_o && phase_o == 2'h3);
endmodule // sub_datapath_checker
bind sub_datapath sub_datapath_checker chk (.sys_clk_i, .nrst_i,
  .insn_i, .phase_o, .busy_o, .file_raddr_o, .file_wr_o, .acc_o, .flags_o);
`default_nettype wire

// File: testbench/sub_datapath_test.sv
`timescale 1ns/1ps
`default_nettype none
module sub_datapath_test;
  logic                 sys_clk_i = 1'b0;
  logic                 nrst_i = 1'b0;
  logic [13:0]          insn_i = 14'h0000;
  logic [7:0]           file_rdata_i = 8'h00;
  logic [1:0]           phase_o;
  logic                 busy_o;
  logic [6:0]           file_raddr_o;
  sub_dp_pkg::file_wr_t file_wr_o;
  logic [7:0]           acc_o;
  sub_dp_pkg::flags_t   flags_o;
  int                   errors = 0;
  int                   compares = 0;
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  sub_datapath DUT (.sys_clk_i, .nrst_i, .insn_i, .file_rdata_i, .phase_o,
    .busy_o, .file_raddr_o, .file_wr_o, .acc_o, .flags_o);
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one word at decode; the write pulse still stands when we look
  task automatic run(input logic [13:0] i, input logic [7:0] r,
                     input logic [15:0] w, input logic [7:0] a,
                     input logic [2:0] f);
    insn_i = i;
    file_rdata_i = r;
    @(posedge sys_clk_i);
    #5;
    // read phase: index latched, busy only for a subtract word
    chk({17'h0, phase_o, busy_o, file_raddr_o},
        {17'h0, 2'h1, (i[13:8] == 6'h02 || i[13:9] == 5'h1E),
         i[6:0]});
    repeat (3) @(posedge sys_clk_i);
    #5;
    chk({file_wr_o.we ? 16'(file_wr_o) : 16'h0000, acc_o, flags_o},
        {w, a, f});
    chk({24'h0, phase_o, busy_o}, 27'h0);
  endtask
  // literal minus acc, both opcode forms; read data must be ignored
  task automatic lit_case;
    run(14'h3C01, 8'hA5, 16'h0000, 8'h01, 3'b110);
    run(14'h3D02, 8'hA5, 16'h0000, 8'h01, 3'b110);
    run(14'h3C01, 8'hA5, 16'h0000, 8'h00, 3'b111);
    run(14'h3D03, 8'hA5, 16'h0000, 8'h03, 3'b110);
    run(14'h3C02, 8'hA5, 16'h0000, 8'hFF, 3'b000);
    run(14'h3D10, 8'hA5, 16'h0000, 8'h11, 3'b000);
    run(14'h3C20, 8'hA5, 16'h0000, 8'h0F, 3'b100);
  endtask
  // register minus acc to either destination
  task automatic file_case;
    run(14'h0205, 8'h1F, 16'h0000, 8'h10, 3'b110);
    run(14'h02FF, 8'h0F, 16'hFFFF, 8'h10, 3'b010);
    run(14'h02C0, 8'h10, 16'hC000, 8'h10, 3'b111);
    run(14'h0201, 8'h00, 16'h0000, 8'hF0, 3'b010);
  endtask
  // other opcodes leave state alone
  task automatic other_case;
    run(14'h0705, 8'h33, 16'h0000, 8'hF0, 3'b010);
    run(14'h3E05, 8'h33, 16'h0000, 8'hF0, 3'b010);
  endtask
  // reset between instructions, at decode with none in progress, clears state and restarts at decode
  task automatic reset_case;
    nrst_i = 1'b0;
    @(posedge sys_clk_i);
    #5;
    nrst_i = 1'b1;
    chk({14'h0, phase_o, acc_o, flags_o}, 27'h0);
    run(14'h3C05, 8'h00, 16'h0000, 8'h05, 3'b110);
  endtask
  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    #5;
    nrst_i = 1'b1;
    lit_case();
    file_case();
    other_case();
    reset_case();
    test_done();
  end
  // watchdog well past the 67 or so cycles needed
  initial
  begin
    #20000;
    errors++;
    test_done();
  end
endmodule // sub_datapath_test
`default_nettype wire
